/* rtl/dbd_pkg.sv */
package dbd_pkg;

  // ----------------------------------------
  // Word framing
  // ----------------------------------------
  localparam int LANES = 3;
  localparam int SLOTS_PER_WORD = 9;
  localparam int PAYLOAD_BITS = 7;
  localparam logic [3:0] SLOT_FIRST = 4'h0;
  localparam logic [3:0] SLOT_LAST = 4'h8;
  localparam logic [3:0] SLOT_SAT = 4'hF;
  localparam logic [3:0] STROBE_SLOT = 4'h4;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam logic [4:0] LOST_CYCLES = 5'h12;
  localparam int LOCK_PERIODS_DEFAULT = 32800;

  // One received lane word, first serial bit in payload[0]
  typedef struct packed {
    logic flagN;
    logic flagInv;
    logic [PAYLOAD_BITS-1:0] payload;
  } dbd_word_type;

  // Parallel output bus, lane 0 in the low bits
  typedef struct packed {
    logic [PAYLOAD_BITS-1:0] lane2;
    logic [PAYLOAD_BITS-1:0] lane1;
    logic [PAYLOAD_BITS-1:0] lane0;
  } dbd_par_type;

endpackage

/* rtl/dbd_deser.sv */
// Summary of operation
// - Only the balanced inversion coding is decoded; no raw mode exists.
// - Clock frequency change or hot plug just restarts locking, no power cycle.
// - Exactly nine bit slots per link clock period on every lane.
// - Stopped or slow link clock forces all parallel outputs low.
// - Lane held static low drives its own outputs low.
// - Power-down low tri-states all outputs and halts the lock logic.
// - After power-down release outputs are driven low until lock.
// - Lock is reached whatever order clock, power-down and supply arrive.
// - Lock counter on link periods, at most 32800; outputs low meanwhile.
// - Seven payload bits plus two complementary flags; inversion is undone.
// - Output data valid at rising or falling output clock edge per variant.
// - Lane 0 feeds outputs 0..6, lane 1 feeds outputs 7..13.
module dbd_deser #(
  parameter int LOCK_PERIODS = dbd_pkg::LOCK_PERIODS_DEFAULT,
  parameter bit RISING_STROBE = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic powerDownN,
  input wire logic linkClockIn,
  input wire logic [dbd_pkg::LANES-1:0] serialLaneIn,
  output logic [dbd_pkg::PAYLOAD_BITS-1:0] lane0ParallelOut,
  output logic [dbd_pkg::PAYLOAD_BITS-1:0] lane1ParallelOut,
  output logic [dbd_pkg::PAYLOAD_BITS-1:0] lane2ParallelOut,
  output logic parallelOutEn,
  output logic parallelClockOut,
  output logic parallelClockOutEn
);

  localparam int LW = $clog2(LOCK_PERIODS + 1);
  localparam logic [LW-1:0] LOCK_DONE = LW'(LOCK_PERIODS);
  localparam logic [LW-1:0] LOCK_ONE = LW'(1);

  // ----------------------------------------
  // Word decode
  // ----------------------------------------
  // Undo inversion; invalid flag pair (static lane) yields zero
  function automatic logic [dbd_pkg::PAYLOAD_BITS-1:0] decodeWord(input dbd_pkg::dbd_word_type w);
    logic [dbd_pkg::PAYLOAD_BITS-1:0] r;
    r = '0;
    if (w.flagInv != w.flagN) begin
      r = w.flagInv ? ~w.payload : w.payload;
    end
    return r;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic linkPrev_q;
  logic [3:0] slot_q, slot_d;
  logic [4:0] idle_q, idle_d;
  logic [LW-1:0] lockCnt_q, lockCnt_d;
  dbd_pkg::dbd_word_type [dbd_pkg::LANES-1:0] shift_q, shift_d;
  dbd_pkg::dbd_par_type data_q, data_d, decoded;
  logic clkOut_q, clkOut_d;
  logic outEn_q;

  // Edge, framing, loss and lock decode
  wire linkRise = linkClockIn & ~linkPrev_q;
  wire goodFrame = linkRise & (slot_q == dbd_pkg::SLOT_LAST);
  wire badFrame = linkRise & (slot_q != dbd_pkg::SLOT_LAST);
  wire clkLost = (idle_q >= dbd_pkg::LOST_CYCLES);
  wire locked = (lockCnt_q == LOCK_DONE);
  wire lockClear = ~powerDownN | clkLost | badFrame;
  wire quietOut = ~powerDownN | ~locked | clkLost;

  // Slot and idle counters, held at SLOT_SAT and zero in power-down
  assign slot_d = ~powerDownN ? dbd_pkg::SLOT_SAT :
                  linkRise ? dbd_pkg::SLOT_FIRST :
                  (slot_q == dbd_pkg::SLOT_SAT) ? slot_q : slot_q + 4'h1;
  assign idle_d = (~powerDownN | linkRise) ? 5'h00 :
                  clkLost ? idle_q : idle_q + 5'h01;

  // Lock interval counter, counted in link periods
  assign lockCnt_d = lockClear ? '0 :
                     (goodFrame & ~locked) ? lockCnt_q + LOCK_ONE : lockCnt_q;

  // Lane mapping onto the parallel bus
  assign decoded.lane0 = decodeWord(shift_q[0]);
  assign decoded.lane1 = decodeWord(shift_q[1]);
  assign decoded.lane2 = decodeWord(shift_q[2]);
  assign data_d = quietOut ? '0 : goodFrame ? decoded : data_q;

  // Output strobe edge placed mid-word
  assign clkOut_d = ~quietOut & ((slot_d >= dbd_pkg::STROBE_SLOT) == RISING_STROBE);

  // Serial shift, first bit ends in payload bit 0
  always_comb begin
    for (int i = 0; i < dbd_pkg::LANES; i++) begin
      shift_d[i] = powerDownN ? {serialLaneIn[i], shift_q[i][dbd_pkg::SLOTS_PER_WORD-1:1]} : shift_q[i];
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      linkPrev_q <= 1'b0;
      slot_q <= dbd_pkg::SLOT_SAT;
      idle_q <= 5'h00;
      lockCnt_q <= '0;
      shift_q <= '0;
    end else begin
      linkPrev_q <= linkClockIn;
      slot_q <= slot_d;
      idle_q <= idle_d;
      lockCnt_q <= lockCnt_d;
      shift_q <= shift_d;
    end
  end

  // Output flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_q <= '0;
      clkOut_q <= 1'b0;
      outEn_q <= 1'b0;
    end else begin
      data_q <= data_d;
      clkOut_q <= clkOut_d;
      outEn_q <= powerDownN;
    end
  end

  assign lane0ParallelOut = data_q.lane0;
  assign lane1ParallelOut = data_q.lane1;
  assign lane2ParallelOut = data_q.lane2;
  assign parallelOutEn = outEn_q;
  assign parallelClockOut = clkOut_q;
  assign parallelClockOutEn = outEn_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence releaseSeq;
    !powerDownN ##1 powerDownN;
  endsequence

  sequence drivenLowSeq;
    parallelOutEn && parallelClockOutEn && (data_q == '0);
  endsequence

  pwrdn_hiz_a: assert property (!powerDownN |=> !parallelOutEn && !parallelClockOutEn && data_q == '0)
    else $error("outputs not released in power-down");
  release_low_a: assert property (releaseSeq |=> drivenLowSeq)
    else $error("outputs not driven low after power-down release");
  locking_low_a: assert property (!locked |=> data_q == '0 && !parallelClockOut)
    else $error("outputs active before lock");
  lock_bound_a: assert property (lockCnt_q <= LOCK_DONE)
    else $error("lock counter beyond limit");
  clk_lost_a: assert property (clkLost |=> data_q == '0 && !parallelClockOut)
    else $error("outputs active with link clock lost");
  frame_relock_a: assert property (powerDownN && badFrame |=> lockCnt_q == '0)
    else $error("bad frame length did not restart locking");
  invert_undo_a: assert property (!quietOut && goodFrame && shift_q[0].flagInv && !shift_q[0].flagN
    |=> lane0ParallelOut == ~$past(shift_q[0].payload))
    else $error("inverted lane 0 word not restored");
  static_lane_a: assert property (goodFrame && shift_q[2] == '0 |=> lane2ParallelOut == '0)
    else $error("static lane 2 not driven low");
  strobe_edge_a: assert property (locked && !clkLost
    && (RISING_STROBE ? $rose(parallelClockOut) : $fell(parallelClockOut))
    |-> slot_q == dbd_pkg::STROBE_SLOT)
    else $error("output clock capture edge at wrong slot");
  hold_word_a: assert property (!quietOut && !goodFrame |=> $stable(data_q) || $past(quietOut))
    else $error("outputs changed outside word boundary");

  // ----------------------------------------
  // Lane mapping and lock bookkeeping checks
  // ----------------------------------------
  // Uninverted word arriving on lane 1
  sequence lane1PlainSeq;
    !quietOut && goodFrame && !shift_q[1].flagInv && shift_q[1].flagN;
  endsequence

  // Uninverted word arriving on lane 2
  sequence lane2PlainSeq;
    !quietOut && goodFrame && !shift_q[2].flagInv && shift_q[2].flagN;
  endsequence

  // Pin enables follow power-down one cycle later
  en_follow_a: assert property ($past(rst_n) |-> parallelOutEn == $past(powerDownN))
    else $error("output enable does not follow power-down");
  // Plain lane 0 word passes unchanged
  lane0_plain_a: assert property (!quietOut && goodFrame && !shift_q[0].flagInv && shift_q[0].flagN
    |=> lane0ParallelOut == $past(shift_q[0].payload))
    else $error("plain lane 0 word altered");
  // Plain lane 1 word lands on bits 7..13
  lane1_plain_a: assert property (lane1PlainSeq |=> lane1ParallelOut == $past(shift_q[1].payload))
    else $error("plain lane 1 word altered");
  // Plain lane 2 word lands on bits 14..20
  lane2_plain_a: assert property (lane2PlainSeq |=> lane2ParallelOut == $past(shift_q[2].payload))
    else $error("plain lane 2 word altered");
  // Equal flag pair gives a silent lane
  flag_equal_a: assert property (goodFrame && shift_q[0].flagInv == shift_q[0].flagN
    |=> lane0ParallelOut == '0)
    else $error("invalid flag pair on lane 0 not driven low");

  // Lock counting and clearing
  pwrdn_clear_a: assert property (!powerDownN |=> lockCnt_q == '0)
    else $error("lock counter kept through power-down");
  lost_clear_a: assert property (clkLost |=> lockCnt_q == '0)
    else $error("lock counter kept with link clock lost");
  lock_step_a: assert property (powerDownN && goodFrame && !clkLost && !locked
    |=> lockCnt_q == $past(lockCnt_q) + LOCK_ONE)
    else $error("lock counter missed a good word");

  // Framing and loss counters stay in range, output clock held low while quiet
  slot_freeze_a: assert property (!powerDownN |=> slot_q == dbd_pkg::SLOT_SAT)
    else $error("slot counter running in power-down");
  idle_limit_a: assert property (idle_q <= dbd_pkg::LOST_CYCLES)
    else $error("idle counter beyond loss threshold");
  clk_quiet_a: assert property (quietOut |=> !parallelClockOut)
    else $error("output clock toggling while quiet");

endmodule

/* sim/dbd_ser_model.sv */
// ----------------------------------------
// Companion serializer model
// ----------------------------------------
module dbd_ser_model (
  input wire logic clk,
  input wire logic run,
  input wire dbd_pkg::dbd_par_type data,
  input wire logic [2:0] inv,
  input wire logic [2:0] mute,
  output logic linkClk,
  output logic [2:0] lanes
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] slotQ = 4'h0;
  logic longQ = 1'b0;
  logic [20:0] word;
  assign word = data;
  // Nine slots a word, steady rate while running
  always_ff @(posedge clk) begin
    slotQ <= (!run || slotQ == 4'h8) ? 4'h0 : slotQ + 4'h1;
    longQ <= (run && slotQ == 4'h8) ? ~longQ : longQ;
  end
  // Clock high four or five slots in turn, still when stopped
  assign linkClk = run && (slotQ < (longQ ? 4'h5 : 4'h4));
  // Payload first, then the inversion flag and its complement
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!run || mute[i]) lanes[i] = 1'b0;
      else if (slotQ < 4'h7) lanes[i] = word[i*7+slotQ] ^ inv[i];
      else lanes[i] = (slotQ == 4'h7) ? inv[i] : ~inv[i];
    end
  end
endmodule

/* sim/dc_balanced_deser_power_lock_tb.sv */
module dc_balanced_deser_power_lock_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic powerDownN = 1'b0;
  logic run = 1'b0;
  logic linkClk, oe, ck, ckEn;
  logic [2:0] inv = 3'h0;
  logic [2:0] mute = 3'h0;
  logic [2:0] lanes;
  logic [6:0] o0, o1, o2;
  logic [6:0] f0, f1, f2;
  logic fOe, fCk, fCkEn;
  dbd_pkg::dbd_par_type data = 21'h1A2B3C;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  initial forever #20 clk = ~clk;
  dbd_ser_model i_ser (.clk(clk), .run(run), .data(data), .inv(inv), .mute(mute), .linkClk(linkClk), .lanes(lanes));
  dbd_deser #(.LOCK_PERIODS(4), .RISING_STROBE(1'b1)) i_dut (.clk(clk), .rst_n(rst_n), .powerDownN(powerDownN),
    .linkClockIn(linkClk), .serialLaneIn(lanes), .lane0ParallelOut(o0), .lane1ParallelOut(o1),
    .lane2ParallelOut(o2), .parallelOutEn(oe), .parallelClockOut(ck), .parallelClockOutEn(ckEn));
  // Falling-strobe variant on the same link
  dbd_deser #(.LOCK_PERIODS(4), .RISING_STROBE(1'b0)) i_dut_fall (.clk(clk), .rst_n(rst_n),
    .powerDownN(powerDownN), .linkClockIn(linkClk), .serialLaneIn(lanes), .lane0ParallelOut(f0),
    .lane1ParallelOut(f1), .lane2ParallelOut(f2), .parallelOutEn(fOe), .parallelClockOut(fCk),
    .parallelClockOutEn(fCkEn));
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkBit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: bit got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_power;
    powerDownN <= 1'b0;
    cycles(3);
    chk({19'h0, oe, ckEn}, 21'h0);
    @(posedge clk) powerDownN <= 1'b1;
    cycles(2);
    chk({19'h0, oe, ckEn}, 21'h3);
    $display("test power done");
  endtask
  task automatic t_lock;
    repeat (30) begin
      cycles(1);
      chk({o2, o1, o0}, 21'h0);
      chkBit(ck, 1'b0);
    end
    cycles(90);
    chk({o2, o1, o0}, data);
    $display("test lock done");
  endtask
  task automatic t_data;
    logic [2:0] invs [4] = '{3'h7, 3'h5, 3'h2, 3'h0};
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) inv <= invs[k];
      data <= 21'h15A5A5 ^ (21'h0F0F0F << k);
      cycles(27);
      chk({o2, o1, o0}, data);
    end
    $display("test data done");
  endtask
  task automatic t_static;
    @(posedge clk) mute <= 3'h2;
    cycles(27);
    chk({o2, o1, o0}, {data.lane2, 7'h00, data.lane0});
    @(posedge clk) mute <= 3'h0;
    $display("test static done");
  endtask
  task automatic t_lost;
    @(posedge clk) run <= 1'b0;
    cycles(25);
    chk({o2, o1, o0}, 21'h0);
    chkBit(ck, 1'b0);
    @(posedge clk) run <= 1'b1;
    t_lock;
    $display("test lost done");
  endtask
  task automatic t_strobe;
    int nRise;
    int nFall;
    logic ckPrev;
    logic fPrev;
    nRise = 0;
    nFall = 0;
    ckPrev = ck;
    fPrev = fCk;
    repeat (18) begin
      cycles(1);
      if (ck && !ckPrev) nRise++;
      if (!fCk && fPrev) nFall++;
      ckPrev = ck;
      fPrev = fCk;
    end
    chk(21'(nRise), 21'h2);
    chk(21'(nFall), 21'h2);
    chk({f2, f1, f0}, data);
    $display("test strobe done");
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    run <= 1'b1;
    t_power;
    t_lock;
    t_strobe;
    t_data;
    t_static;
    t_lost;
    conclude;
  end
  // Hang limit
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      conclude;
    end
  end
endmodule
